// >>> tpg_pkg.sv
// Purpose: shared constants and types of the test pattern generator
// Assumes: byte-wide register port, 100 MHz clock
// Notes:   page 0 offsets double as indices of the register array
package tpg_pkg;
   // main-map offsets of the indirect window
   localparam logic [7:0] MAIN_IND_CTL   = 8'hB0;
   localparam logic [7:0] MAIN_IND_ADDR  = 8'hB1;
   localparam logic [7:0] MAIN_IND_DATA  = 8'hB2;
   localparam int         IND_AUTOINC    = 1;
   localparam int         IND_SEL_LSB    = 2;
   localparam int         IND_SEL_MSB    = 5;
   localparam logic [7:0] IND_CTL_MASK   = 8'h3E;
   localparam logic [7:0] IND_CTL_RESET  = 8'h00;
   localparam logic [7:0] IND_OFS_RESET  = 8'h00;
   localparam logic [3:0] PAGE_PGEN      = 4'h0;
   // page 0 offsets
   localparam int OFS_CONTROL  = 1;
   localparam int OFS_CONFIG   = 2;
   localparam int OFS_IDENT    = 3;
   localparam int OFS_LINE_HI  = 4;
   localparam int OFS_LINE_LO  = 5;
   localparam int OFS_BAR_HI   = 6;
   localparam int OFS_BAR_LO   = 7;
   localparam int OFS_ACT_HI   = 8;
   localparam int OFS_ACT_LO   = 9;
   localparam int OFS_FRAME_HI = 10;
   localparam int OFS_FRAME_LO = 11;
   localparam int PAGE_REGS    = 12;
   // field positions
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CFG_SOLID_BIT  = 7;
   localparam int CFG_BARS_MSB   = 5;
   localparam int CFG_BARS_LSB   = 4;
   localparam int CFG_BLOCK_MSB  = 3;
   localparam int CFG_BLOCK_LSB  = 0;
   localparam int ID_VC_MSB      = 7;
   localparam int ID_VC_LSB      = 6;
   localparam int ID_DT_MSB      = 5;
   localparam int ID_DT_LSB      = 0;
   // reset values, index is the page offset
   localparam logic [7:0] PAGE_RESET [PAGE_REGS] = '{
      8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80,
      8'h00, 8'hF0, 8'h01, 8'hE0, 8'h02, 8'h0D};
   // byte values of bars and fixed blocks
   localparam logic [7:0] COLOR_TABLE [16] = '{
      8'hAA, 8'h33, 8'hF0, 8'h0F, 8'h55, 8'hCC, 8'hFF, 8'h00,
      8'h11, 8'h22, 8'h44, 8'h88, 8'h66, 8'h99, 8'h77, 8'hEE};
   // idle slot between lines
   localparam int CLK_PERIOD_NS = 10;
   localparam int LINE_GAP_NS   = 80;
   localparam int GAP_CYCLES    = (LINE_GAP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int GAP_W         = $clog2(GAP_CYCLES + 1);
   typedef enum logic [1:0] {
      TPG_KIND_FS   = 2'h0,
      TPG_KIND_FE   = 2'h1,
      TPG_KIND_LINE = 2'h2
   } tpg_kind_e;
   typedef enum logic [2:0] {
      TPG_IDLE  = 3'b000,
      TPG_FS    = 3'b001,
      TPG_GAP   = 3'b011,
      TPG_LINE  = 3'b010,
      TPG_BLANK = 3'b110,
      TPG_FE    = 3'b111
   } tpg_state_e;
   // index of the last bar for a bar count code
   function automatic logic [2:0] tpg_bar_last(input logic [1:0] code);
      tpg_bar_last = 3'((4'h1 << code) - 4'h1);
   endfunction
endpackage

// >>> tpg_gen_if.sv
// Purpose: link between frame sequencer and byte source
// Assumes: one clock, signals change on its rising edge
// Notes:   data is combinational from the source state
`timescale 1ns/100ps
`default_nettype none
interface tpg_gen_if;
   logic        line_start;
   logic        step;
   logic        solid;
   logic [1:0]  bar_code;
   logic [15:0] bar_len;
   logic [3:0]  block_size;
   logic [7:0]  data;
   modport ctrl (output line_start, step, solid, bar_code, bar_len,
                 block_size, input data);
   modport gen  (input line_start, step, solid, bar_code, bar_len,
                 block_size, output data);
endinterface
`default_nettype wire

// >>> tpg_byte_source.sv
// Purpose: byte values of bar and fixed block patterns
// Assumes: line_start comes before the first step of a line
// Notes:   block size 0 behaves as size 1
`timescale 1ns/100ps
`default_nettype none
module tpg_byte_source (
   input  wire logic clk,
   input  wire logic rst,
   tpg_gen_if.gen    g
);
   logic [2:0]  bar_idx;
   logic [15:0] bar_pos;
   logic [3:0]  blk_pos;
   logic [2:0]  next_bar_idx;
   logic [15:0] next_bar_pos;
   logic [3:0]  next_blk_pos;
   logic [2:0]  last_bar;

   assign last_bar = tpg_pkg::tpg_bar_last(g.bar_code);
   // solid blocks or bars pick the byte
   assign g.data = g.solid ? tpg_pkg::COLOR_TABLE[blk_pos]
                           : tpg_pkg::COLOR_TABLE[{1'b0, bar_idx}];

   // position within bar and block
   always_comb begin
      next_bar_idx = bar_idx;
      next_bar_pos = bar_pos;
      next_blk_pos = blk_pos;
      if (g.line_start) begin
         next_bar_idx = 3'h0;
         next_bar_pos = 16'h0000;
         next_blk_pos = 4'h0;
      end else if (g.step) begin
         if (g.solid) begin
            if (blk_pos + 4'h1 >= g.block_size) begin
               next_blk_pos = 4'h0;
            end else begin
               next_blk_pos = blk_pos + 4'h1;
            end
         end else if (bar_pos + 16'h0001 >= g.bar_len &&
                      bar_idx < last_bar) begin
            next_bar_idx = bar_idx + 3'h1;
            next_bar_pos = 16'h0000;
         end else begin
            next_bar_pos = bar_pos + 16'h0001; // last bar fills the rest
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bar_idx <= 3'h0;
         bar_pos <= 16'h0000;
         blk_pos <= 4'h0;
      end else begin
         bar_idx <= next_bar_idx;
         bar_pos <= next_bar_pos;
         blk_pos <= next_blk_pos;
      end
   end

   property p_bar_bound;
      @(posedge clk) disable iff (rst)
      !g.solid && g.step && !g.line_start && $stable(g.bar_code) &&
      bar_idx <= last_bar |=> bar_idx <= last_bar;
   endproperty
   a_bar_bound: assert property (p_bar_bound)
      else $error("bar index beyond bar count");

   property p_bar_advance;
      @(posedge clk) disable iff (rst)
      !g.solid && g.step && !g.line_start &&
      bar_pos + 16'h0001 == g.bar_len && bar_idx < last_bar
      |=> bar_idx == $past(bar_idx) + 3'h1 && bar_pos == 16'h0000;
   endproperty
   a_bar_advance: assert property (p_bar_advance)
      else $error("bar did not advance at bar length");

   property p_block_wrap;
      @(posedge clk) disable iff (rst)
      g.solid && g.step && !g.line_start && g.block_size != 4'h0 &&
      blk_pos == g.block_size - 4'h1 |=> blk_pos == 4'h0;
   endproperty
   a_block_wrap: assert property (p_block_wrap)
      else $error("fixed block did not wrap at block size");
endmodule // tpg_byte_source
`default_nettype wire

// >>> tpg_pattern_top.sv
// Purpose: test pattern frame generator behind an indirect window
// Assumes: register port driven by logic on CLK; sink never stalls
// Notes:   a frame in flight completes after the enable is cleared
// Function
// - frames start when the enable bit is 1; none while 0, reset 0
// - config bit 7 picks bars at 0 or fixed color blocks at 1
// - bar count code 00,01,10,11 gives 1,2,4,8 bars; reset 3
// - fixed blocks are 1 to 15 bytes from config bits 3:0; reset 3
// - identifier bits 7:6 are the virtual channel of every packet
// - identifier bits 5:0 are the data type, reset 0x24
// - each active line carries the 16-bit line length in bytes
// - bars except the last are bar length bytes; last fills the line
// - active lines per frame come from a 16-bit count, reset 480
// - total lines per frame include blanking; high byte at 0x0A
// - generator registers sit in page 0; window at 0xB0 to 0xB2
`timescale 1ns/100ps
`default_nettype none
module tpg_pattern_top (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   output logic      [7:0]  REG_RDATA,
   output logic             PKT_STROBE,
   output logic      [1:0]  PKT_KIND,
   output logic      [1:0]  PKT_VC,
   output logic      [5:0]  PKT_DT,
   output logic      [15:0] PKT_WC,
   output logic             BYTE_VALID,
   output logic      [7:0]  BYTE_DATA,
   output logic             BYTE_LAST
);
   localparam int GAP_W_L = tpg_pkg::GAP_W;
   localparam logic [GAP_W_L-1:0] GAP_END = GAP_W_L'(tpg_pkg::GAP_CYCLES - 1);

   tpg_gen_if g ();

   logic [7:0]  ind_ctl;
   logic [7:0]  ind_ofs;
   logic [7:0]  pg [tpg_pkg::PAGE_REGS];
   logic [7:0]  next_ind_ctl;
   logic [7:0]  next_ind_ofs;
   logic [7:0]  next_pg [tpg_pkg::PAGE_REGS];
   logic [7:0]  next_rdata;
   logic        page0;
   logic        ofs_valid;
   logic        data_hit;
   logic        generator_on;
   logic [1:0]  packet_virtual_channel;
   logic [5:0]  packet_data_type;
   logic [15:0] line_length_bytes;
   logic [15:0] active_line_count;
   logic [15:0] frame_line_count;

   tpg_pkg::tpg_state_e state;
   tpg_pkg::tpg_state_e next_state;
   logic [15:0] line_no;
   logic [15:0] byte_cnt;
   logic [GAP_W_L-1:0] gap_cnt;
   logic [15:0] next_line_no;
   logic [15:0] next_byte_cnt;
   logic [GAP_W_L-1:0] next_gap_cnt;
   logic        next_strobe;
   logic [1:0]  next_kind;
   logic [15:0] next_wc;
   logic        next_bvalid;
   logic        next_blast;
   logic        start_line;
   logic        step;

   // configuration fields
   assign generator_on = pg[tpg_pkg::OFS_CONTROL][tpg_pkg::CTL_ENABLE_BIT];
   assign packet_virtual_channel =
      pg[tpg_pkg::OFS_IDENT][tpg_pkg::ID_VC_MSB:tpg_pkg::ID_VC_LSB];
   assign packet_data_type =
      pg[tpg_pkg::OFS_IDENT][tpg_pkg::ID_DT_MSB:tpg_pkg::ID_DT_LSB];
   assign line_length_bytes = {pg[tpg_pkg::OFS_LINE_HI],
                               pg[tpg_pkg::OFS_LINE_LO]};
   assign active_line_count = {pg[tpg_pkg::OFS_ACT_HI],
                               pg[tpg_pkg::OFS_ACT_LO]};
   assign frame_line_count = {pg[tpg_pkg::OFS_FRAME_HI],
                              pg[tpg_pkg::OFS_FRAME_LO]};

   // byte source hookup
   assign g.line_start = start_line;
   assign g.step       = step;
   assign g.solid      = pg[tpg_pkg::OFS_CONFIG][tpg_pkg::CFG_SOLID_BIT];
   assign g.bar_code   =
      pg[tpg_pkg::OFS_CONFIG][tpg_pkg::CFG_BARS_MSB:tpg_pkg::CFG_BARS_LSB];
   assign g.block_size =
      pg[tpg_pkg::OFS_CONFIG][tpg_pkg::CFG_BLOCK_MSB:tpg_pkg::CFG_BLOCK_LSB];
   assign g.bar_len    = {pg[tpg_pkg::OFS_BAR_HI], pg[tpg_pkg::OFS_BAR_LO]};

   tpg_byte_source u_src (
      .clk (CLK),
      .rst (RST),
      .g   (g.gen)
   );

   // indirect window decode
   assign page0 = ind_ctl[tpg_pkg::IND_SEL_MSB:tpg_pkg::IND_SEL_LSB]
                  == tpg_pkg::PAGE_PGEN;
   assign ofs_valid = ind_ofs != 8'h00 &&
                      ind_ofs < 8'(tpg_pkg::PAGE_REGS);
   assign data_hit = REG_ADDR == tpg_pkg::MAIN_IND_DATA;

   // register window next values
   always_comb begin
      next_ind_ctl = ind_ctl;
      next_ind_ofs = ind_ofs;
      next_pg      = pg;
      next_rdata   = REG_RDATA;
      if (REG_WR) begin
         if (REG_ADDR == tpg_pkg::MAIN_IND_CTL) begin
            next_ind_ctl = REG_WDATA & tpg_pkg::IND_CTL_MASK;
         end
         if (REG_ADDR == tpg_pkg::MAIN_IND_ADDR) begin
            next_ind_ofs = REG_WDATA;
         end
         if (data_hit && page0 && ofs_valid) begin
            next_pg[ind_ofs[3:0]] = REG_WDATA;
         end
      end
      if (REG_RD) begin
         unique case (REG_ADDR)
            tpg_pkg::MAIN_IND_CTL:  next_rdata = ind_ctl;
            tpg_pkg::MAIN_IND_ADDR: next_rdata = ind_ofs;
            tpg_pkg::MAIN_IND_DATA:
               next_rdata = (page0 && ofs_valid) ? pg[ind_ofs[3:0]]
                                                 : 8'h00;
            default:                next_rdata = 8'h00;
         endcase
      end
      if ((REG_WR || REG_RD) && data_hit &&
          ind_ctl[tpg_pkg::IND_AUTOINC]) begin
         next_ind_ofs = ind_ofs + 8'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ind_ctl   <= tpg_pkg::IND_CTL_RESET;
         ind_ofs   <= tpg_pkg::IND_OFS_RESET;
         pg        <= tpg_pkg::PAGE_RESET;
         REG_RDATA <= 8'h00;
      end else begin
         ind_ctl   <= next_ind_ctl;
         ind_ofs   <= next_ind_ofs;
         pg        <= next_pg;
         REG_RDATA <= next_rdata;
      end
   end

   // frame sequencer next values
   always_comb begin
      next_state    = state;
      next_line_no  = line_no;
      next_byte_cnt = byte_cnt;
      next_gap_cnt  = gap_cnt;
      next_strobe   = 1'b0;
      next_kind     = PKT_KIND;
      next_wc       = PKT_WC;
      next_bvalid   = 1'b0;
      next_blast    = 1'b0;
      start_line    = 1'b0;
      step          = 1'b0;
      unique case (state)
         tpg_pkg::TPG_IDLE: begin
            if (generator_on) begin
               next_state = tpg_pkg::TPG_FS;
            end
         end
         tpg_pkg::TPG_FS: begin
            next_strobe  = 1'b1;
            next_kind    = tpg_pkg::TPG_KIND_FS;
            next_wc      = 16'h0000;
            next_line_no = 16'h0000;
            next_gap_cnt = '0;
            next_state   = tpg_pkg::TPG_GAP;
         end
         tpg_pkg::TPG_GAP: begin
            next_gap_cnt = gap_cnt + 1'b1;
            if (gap_cnt == GAP_END) begin
               next_gap_cnt  = '0;
               next_byte_cnt = 16'h0000;
               if (line_no < active_line_count) begin
                  next_state  = tpg_pkg::TPG_LINE;
                  next_strobe = 1'b1;
                  next_kind   = tpg_pkg::TPG_KIND_LINE;
                  next_wc     = line_length_bytes;
                  start_line  = 1'b1;
               end else if (line_no < frame_line_count) begin
                  next_state = tpg_pkg::TPG_BLANK;
               end else begin
                  next_state = tpg_pkg::TPG_FE;
               end
            end
         end
         tpg_pkg::TPG_LINE, tpg_pkg::TPG_BLANK: begin
            if (byte_cnt >= line_length_bytes) begin
               next_line_no = line_no + 16'h0001;
               next_state   = tpg_pkg::TPG_GAP;
            end else begin
               next_byte_cnt = byte_cnt + 16'h0001;
               if (state == tpg_pkg::TPG_LINE) begin
                  step        = 1'b1;
                  next_bvalid = 1'b1;
                  next_blast  = byte_cnt + 16'h0001 == line_length_bytes;
               end
            end
         end
         tpg_pkg::TPG_FE: begin
            next_strobe = 1'b1;
            next_kind   = tpg_pkg::TPG_KIND_FE;
            next_wc     = 16'h0000;
            next_state  = generator_on ? tpg_pkg::TPG_FS
                                       : tpg_pkg::TPG_IDLE;
         end
         default: next_state = tpg_pkg::TPG_IDLE;
      endcase
   end

   // sequencer and output flops
   always_ff @(posedge CLK) begin
      if (RST) begin
         state      <= tpg_pkg::TPG_IDLE;
         line_no    <= 16'h0000;
         byte_cnt   <= 16'h0000;
         gap_cnt    <= '0;
         PKT_STROBE <= 1'b0;
         PKT_KIND   <= tpg_pkg::TPG_KIND_FS;
         PKT_VC     <= 2'h0;
         PKT_DT     <= 6'h00;
         PKT_WC     <= 16'h0000;
         BYTE_VALID <= 1'b0;
         BYTE_DATA  <= 8'h00;
         BYTE_LAST  <= 1'b0;
      end else begin
         state      <= next_state;
         line_no    <= next_line_no;
         byte_cnt   <= next_byte_cnt;
         gap_cnt    <= next_gap_cnt;
         PKT_STROBE <= next_strobe;
         PKT_KIND   <= next_kind;
         PKT_VC     <= packet_virtual_channel;
         PKT_DT     <= packet_data_type;
         PKT_WC     <= next_wc;
         BYTE_VALID <= next_bvalid;
         BYTE_DATA  <= step ? g.data : BYTE_DATA;
         BYTE_LAST  <= next_blast;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_idle_stays;
      state == tpg_pkg::TPG_IDLE && !generator_on
      |=> state == tpg_pkg::TPG_IDLE && !PKT_STROBE;
   endproperty
   a_idle_stays: assert property (p_idle_stays)
      else $error("generator left idle while disabled");

   property p_frame_start;
      state == tpg_pkg::TPG_IDLE && generator_on
      |=> ##1 PKT_STROBE && PKT_KIND == tpg_pkg::TPG_KIND_FS;
   endproperty
   a_frame_start: assert property (p_frame_start)
      else $error("no frame start two cycles after enable");

   property p_vc;
      PKT_STROBE |-> PKT_VC == $past(packet_virtual_channel);
   endproperty
   a_vc: assert property (p_vc)
      else $error("packet virtual channel differs from register");

   property p_dt;
      PKT_STROBE |-> PKT_DT == $past(packet_data_type);
   endproperty
   a_dt: assert property (p_dt)
      else $error("packet data type differs from register");

   property p_wc;
      PKT_STROBE && PKT_KIND == tpg_pkg::TPG_KIND_LINE
      |-> PKT_WC == $past(line_length_bytes);
   endproperty
   a_wc: assert property (p_wc)
      else $error("line packet count differs from line length");

   property p_line_bytes;
      PKT_STROBE && PKT_KIND == tpg_pkg::TPG_KIND_LINE && PKT_WC != 16'h0000
      |=> BYTE_VALID;
   endproperty
   a_line_bytes: assert property (p_line_bytes)
      else $error("line packet not followed by payload");

   property p_last_ends;
      BYTE_VALID && BYTE_LAST |=> !BYTE_VALID [*2];
   endproperty
   a_last_ends: assert property (p_last_ends)
      else $error("payload continued past last byte");

   property p_ofs_write;
      REG_WR && REG_ADDR == tpg_pkg::MAIN_IND_ADDR
      |=> ind_ofs == $past(REG_WDATA);
   endproperty
   a_ofs_write: assert property (p_ofs_write)
      else $error("offset register not written");

   property p_autoinc;
      (REG_WR || REG_RD) && data_hit && ind_ctl[tpg_pkg::IND_AUTOINC]
      |=> ind_ofs == $past(ind_ofs) + 8'h01;
   endproperty
   a_autoinc: assert property (p_autoinc)
      else $error("offset did not advance after data access");
endmodule // tpg_pattern_top
`default_nettype wire

// >>> tpg_sink_model.sv
// Purpose: downstream receiver of generated packets and payload bytes
// Assumes: always ready, samples on the rising clock edge
// Notes:   counters and the last line are read by the bench
`timescale 1ns/100ps
`default_nettype none
module tpg_sink_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        pkt_strobe,
   input  wire logic [1:0]  pkt_kind,
   input  wire logic [1:0]  pkt_vc,
   input  wire logic [5:0]  pkt_dt,
   input  wire logic [15:0] pkt_wc,
   input  wire logic        byte_valid,
   input  wire logic [7:0]  byte_data,
   input  wire logic        byte_last
);
   int          n_fs, n_fe, n_line, n_byte, n_bad, age, span;
   logic        in_frame;
   logic [1:0]  vc;
   logic [5:0]  dt;
   logic [15:0] wc;
   logic [7:0]  line_buf [64];

   // packet order, byte capture and end-of-line marking
   always @(posedge clk) begin
      if (rst) begin
         n_fs <= 0;
         n_fe <= 0;
         n_line <= 0;
         n_byte <= 0;
         n_bad <= 0;
         age <= 0;
         span <= 0;
         in_frame <= 1'b0;
      end else begin
         age <= age + 1;
         if (pkt_strobe) begin
            vc <= pkt_vc;
            dt <= pkt_dt;
            case (pkt_kind)
               tpg_pkg::TPG_KIND_FS: begin
                  n_fs <= n_fs + 1;
                  age <= 1;
                  in_frame <= 1'b1;
               end
               tpg_pkg::TPG_KIND_FE: begin
                  n_fe <= n_fe + 1;
                  span <= age;
                  in_frame <= 1'b0;
                  if (pkt_wc != 16'h0000 || !in_frame) begin
                     n_bad <= n_bad + 1;
                  end
               end
               default: begin
                  n_line <= n_line + 1;
                  wc <= pkt_wc;
                  n_byte <= 0;
                  if (!in_frame) n_bad <= n_bad + 1;
               end
            endcase
         end
         if (byte_valid) begin
            line_buf[n_byte % 64] <= byte_data;
            n_byte <= n_byte + 1;
         end
         // last flag only with the final byte of a line
         if (byte_last !== (byte_valid && n_byte + 1 == wc)) begin
            n_bad <= n_bad + 1;
         end
      end
   end
endmodule // tpg_sink_model
`default_nettype wire

// >>> tb_csi2_test_pattern_generator.sv
// Purpose: self-checking bench of the pattern frame generator
// Assumes: sink always ready, register port driven on rising CLK
// Notes:   small frames of 20 byte lines keep the run short
`timescale 1ns/100ps
`default_nettype none
module tb_csi2_test_pattern_generator;
   localparam logic [7:0] IC  = tpg_pkg::MAIN_IND_CTL;
   localparam logic [7:0] IA  = tpg_pkg::MAIN_IND_ADDR;
   localparam logic [7:0] ID  = tpg_pkg::MAIN_IND_DATA;
   localparam int         LEN = 20;
   logic        clk, rst, reg_wr, reg_rd, pkt_strobe, byte_valid, byte_last;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, byte_data, rd;
   logic [1:0]  pkt_kind, pkt_vc;
   logic [5:0]  pkt_dt;
   logic [15:0] pkt_wc;
   int          n_fail, compares, cycles, span3, span4;

   tpg_pattern_top tpg_pattern_top_inst (.CLK(clk), .RST(rst),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .PKT_STROBE(pkt_strobe), .PKT_KIND(pkt_kind), .PKT_VC(pkt_vc),
      .PKT_DT(pkt_dt), .PKT_WC(pkt_wc), .BYTE_VALID(byte_valid),
      .BYTE_DATA(byte_data), .BYTE_LAST(byte_last));
   tpg_sink_model tpg_sink_model_inst (.clk(clk), .rst(rst),
      .pkt_strobe(pkt_strobe), .pkt_kind(pkt_kind), .pkt_vc(pkt_vc),
      .pkt_dt(pkt_dt), .pkt_wc(pkt_wc), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_last(byte_last));

   // 100 MHz clock
   always #5 clk = ~clk;

   // cycle ceiling against a hung wait
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         wrap_up;
      end
   end

   task automatic wrap_up;
      if (n_fail == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle strobes with a quiet cycle after each
   task automatic reg_wr_t(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_rd_t(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic pg_wr(input logic [7:0] ofs, input logic [7:0] d);
      reg_wr_t(IA, ofs);
      reg_wr_t(ID, d);
   endtask

   // reset values through auto-increment reads
   task automatic t_reset_values;
      reg_wr_t(IC, 8'h02);
      reg_wr_t(IA, 8'h01);
      for (int i = 1; i < 12; i++) begin
         reg_rd_t(ID, rd);
         check(32'(rd), 32'(tpg_pkg::PAGE_RESET[i]));
      end
      reg_rd_t(IA, rd);
      check(32'(rd), 32'h0000_000C);
      reg_rd_t(IC, rd);
      check(32'(rd), 32'h0000_0002);
      check(tpg_sink_model_inst.n_fs, 0);
   endtask

   // reserved offset, other block, unmapped main address
   task automatic t_refused;
      pg_wr(8'h00, 8'h5A);
      pg_wr(8'h00, 8'h5A);
      reg_wr_t(IA, 8'h00);
      reg_rd_t(ID, rd);
      check(32'(rd), 32'h0000_0000);
      reg_wr_t(IC, 8'h06);
      pg_wr(8'h03, 8'h55);
      reg_wr_t(IA, 8'h03);
      reg_rd_t(ID, rd);
      check(32'(rd), 32'h0000_0000);
      reg_wr_t(IC, 8'h02);
      reg_wr_t(IA, 8'h03);
      reg_rd_t(ID, rd);
      check(32'(rd), 32'h0000_0024);
      reg_wr_t(IC, 8'h00);
      reg_wr_t(IA, 8'h03);
      reg_rd_t(ID, rd);
      reg_rd_t(ID, rd);
      check(32'(rd), 32'h0000_0024);
      reg_rd_t(IA, rd);
      check(32'(rd), 32'h0000_0003);
      reg_wr_t(IC, 8'h02);
      reg_rd_t(8'h10, rd);
      check(32'(rd), 32'h0000_0000);
   endtask

   // offsets 2 to 0x0B by auto-increment, 20 byte lines, 2 active
   task automatic cfg_frame(input logic [7:0] cfg, input logic [7:0] tot);
      logic [7:0] v [10];
      v = '{cfg, 8'hAA, 8'h00, 8'h14, 8'h00, 8'h03, 8'h00, 8'h02, 8'h00, tot};
      reg_wr_t(IA, 8'h02);
      for (int i = 0; i < 10; i++) reg_wr_t(ID, v[i]);
   endtask

   // one frame, enable cleared while it runs
   task automatic run_frame;
      int f0;
      int l0;
      f0 = tpg_sink_model_inst.n_fs;
      l0 = tpg_sink_model_inst.n_line;
      pg_wr(8'h01, 8'h01);
      while (tpg_sink_model_inst.n_fs == f0) @(posedge clk);
      pg_wr(8'h01, 8'h00);
      while (tpg_sink_model_inst.n_fe == f0) @(posedge clk);
      repeat (200) @(posedge clk);
      check(tpg_sink_model_inst.n_fs, f0 + 1);
      check(tpg_sink_model_inst.n_fe, f0 + 1);
      check(tpg_sink_model_inst.n_line, l0 + 2);
      check(32'(tpg_sink_model_inst.wc), LEN);
      check(tpg_sink_model_inst.n_byte, LEN);
      check(32'(tpg_sink_model_inst.vc), 32'h0000_0002);
      check(32'(tpg_sink_model_inst.dt), 32'h0000_002A);
      check(tpg_sink_model_inst.n_bad, 0);
   endtask

   task automatic t_bars(input logic [1:0] code);
      int last;
      int bar;
      logic [7:0] e;
      last = (1 << code) - 1;
      cfg_frame({2'b00, code, 4'h3}, 8'h03);
      run_frame;
      span3 = tpg_sink_model_inst.span;
      for (int k = 0; k < LEN; k++) begin
         bar = (k / 3 > last) ? last : k / 3;
         e = tpg_pkg::COLOR_TABLE[bar];
         check(32'(tpg_sink_model_inst.line_buf[k]), 32'(e));
      end
   endtask

   task automatic t_solid;
      logic [7:0] e;
      cfg_frame(8'h85, 8'h04);
      run_frame;
      span4 = tpg_sink_model_inst.span;
      for (int k = 0; k < LEN; k++) begin
         e = tpg_pkg::COLOR_TABLE[k % 5];
         check(32'(tpg_sink_model_inst.line_buf[k]), 32'(e));
      end
      check(span4 - span3, LEN + 9);
   endtask

   // back-to-back frames while the enable stays set
   task automatic t_repeat;
      int f0;
      f0 = tpg_sink_model_inst.n_fs;
      pg_wr(8'h01, 8'h01);
      while (tpg_sink_model_inst.n_fs < f0 + 2) @(posedge clk);
      pg_wr(8'h01, 8'h00);
      while (tpg_sink_model_inst.n_fe < f0 + 2) @(posedge clk);
      repeat (200) @(posedge clk);
      check(tpg_sink_model_inst.n_fs, f0 + 2);
      check(tpg_sink_model_inst.n_fe, f0 + 2);
      check(tpg_sink_model_inst.n_bad, 0);
   endtask

   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      n_fail = 0;
      compares = 0;
      cycles = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset_values;
      t_refused;
      for (int c = 0; c < 4; c++) t_bars(2'(c));
      t_solid;
      t_repeat;
      wrap_up;
   end
endmodule // tb_csi2_test_pattern_generator
`default_nettype wire
